// ---- core/servo_map.svh ----
`ifndef SERVO_MAP_SVH
`define SERVO_MAP_SVH

// ****************************************
// Register byte offsets
// ****************************************
`define A_AXSEL 8'h00
`define A_CMD 8'h04
`define A_CTRL 8'h08
`define A_STATUS 8'h0C
`define A_SETPT 8'h10
`define A_TOFF 8'h14
`define A_FB 8'h18
`define A_VEL 8'h1C
`define A_INOW 8'h20
`define A_ERR 8'h24
`define A_ECODE 8'h28
`define A_PBASE 8'h40
`define A_PEND 8'h84

// ****************************************
// Parameter word indexes in the staging set
// ****************************************
`define P_A2 0
`define P_A1 1
`define P_A0 2
`define P_B2 3
`define P_B1 4
`define P_B0 5
`define P_ICP 6
`define P_ICN 7
`define P_MODE 8
`define P_DIV 9
`define P_ILIM 10
`define P_ILIMMAX 11
`define P_PLO 12
`define P_PHI 13
`define P_ADCA 14
`define P_ADCB 15
`define P_IPOLE 16
`define PARAM_N 17

// ****************************************
// Mode word option bits; command, control, status and error code bits
// ****************************************
`define M_FRIC 4
`define M_ANALOG_FEEDBACK_SEL 5
`define M_OPEN 6
`define M_ANALOG_DEMAND_SEL 7
`define M_ANALOG_TORQUE_OFFSET_SEL 8
`define M_PCHK 9
`define M_SOFT 10
`define CMD_WR 0
`define CMD_RD 1
`define CTRL_OFF 0
`define CTRL_CLR 1
`define ST_SHUT 0
`define ST_PANIC 1
`define E_PLO 0
`define E_PHI 1
`define E_ILIM 2
`define E_PANIC 3

// ****************************************
// Reset values and timing counts
// ****************************************
`define RST_ONE 32'h00000001
`define PANIC_HOLD 3'h7

`endif

// ---- core/servo_pkg.sv ----
`include "servo_map.svh"

package servo_pkg;
  // Operating mode held in the low bits of the mode word
  typedef enum logic [2:0] {
    mode_unservoed,
    mode_position,
    mode_velocity,
    mode_current,
    mode_triangle_test
  } mode_t;
  typedef logic signed [31:0] word_t;
  typedef word_t [`PARAM_N-1:0] param_t;
  // Compensator and differentiator history of one axis
  typedef struct packed {
    word_t e1;
    word_t e2;
    word_t u1;
    word_t u2;
    word_t y1;
    word_t y2;
  } hist_t;
  // Readable servo state of one axis
  typedef struct packed {
    word_t fb;
    word_t vel;
    word_t inow;
    word_t err;
  } axis_state_t;
  // Sequencer walking the axes after a sample tick
  typedef enum logic {seq_idle, seq_run} seq_t;
endpackage

// ---- core/pin_sync.sv ----
`timescale 1ns/1ps
module pin_sync (
  // Clock and reset
  input wire logic sys_clk_i,
  input wire logic rst_n_i,
  // Pin in, filtered level out
  input wire logic pin_i,
  output logic level_o
);
  logic s1_ff; // First stage, read only by the second
  logic s2_ff;
  logic s3_ff;
  logic nxt_level;

  // A change counts once the second and third stages agree
  always_comb begin
    nxt_level = (s2_ff == s3_ff) ? s2_ff : level_o;
  end

  // Register chain
  always_ff @(posedge sys_clk_i or negedge rst_n_i) begin
    if (!rst_n_i) begin
      s1_ff <= 1'b0;
      s2_ff <= 1'b0;
      s3_ff <= 1'b0;
      level_o <= 1'b0;
    end else begin
      s1_ff <= pin_i;
      s2_ff <= s1_ff;
      s3_ff <= s2_ff;
      level_o <= nxt_level;
    end
  end
endmodule // pin_sync

// ---- core/servo_math.sv ----
`timescale 1ns/1ps
`include "servo_map.svh"
module servo_math import servo_pkg::*; (
  // Axis parameters and history
  input wire param_t prm_i,
  input wire hist_t hist_i,
  // Feedback sample and setpoint
  input wire word_t fb_i,
  input wire word_t sp_i,
  input wire logic vel_sel_i,
  input wire logic open_i,
  // Results
  output word_t vel_o,
  output word_t err_o,
  output word_t comp_o
);
  word_t fbsel; // Quantity fed back into the loop
  word_t num; // Compensator numerator sum

  // Three point derivative, error and second order compensator
  always_comb begin
    vel_o = (fb_i + fb_i + fb_i - (hist_i.y1 <<< 2) + hist_i.y2)
            / word_t'(2);
    fbsel = open_i ? '0 : (vel_sel_i ? vel_o : fb_i);
    err_o = sp_i - fbsel;
    // Products wrap at 32 bits; coefficient scaling is software's job
    num = prm_i[`P_A2] * hist_i.e2 + prm_i[`P_A1] * hist_i.e1
        + prm_i[`P_A0] * err_o - prm_i[`P_B2] * hist_i.u2
        - prm_i[`P_B1] * hist_i.u1;
    // A zero b0 would divide by zero, so it is taken as one
    comp_o = (prm_i[`P_B0] == '0) ? num : num / prm_i[`P_B0];
  end
endmodule // servo_math

// ---- core/servo_ctrl.sv ----
// Our own choices: register access over APB and the register addresses.
`timescale 1ns/1ps
`include "servo_map.svh"
module servo_ctrl import servo_pkg::*; #(
  parameter int NAXES = 16,
  parameter int DAC_W = 16,
  parameter int ADC_W = 16
) (
  // Clock and reset
  input wire logic sys_clk_i,
  input wire logic rst_n_i,
  // APB slave
  input wire logic psel_i,
  input wire logic penable_i,
  input wire logic pwrite_i,
  input wire logic [7:0] paddr_i,
  input wire logic [31:0] pwdata_i,
  output logic [31:0] prdata_o,
  output logic pready_o,
  output logic pslverr_o,
  // Sample tick and shared open-drain fault line, low active
  input wire logic sample_tick_i,
  input wire logic panic_n_i,
  output logic panic_n_o,
  output logic panic_oe_o,
  // Motor interface cards
  input wire logic [NAXES-1:0][31:0] enc_count_i,
  input wire logic [NAXES-1:0][ADC_W-1:0] adc_raw_i,
  output logic [NAXES-1:0][DAC_W-1:0] dac_o
);
  localparam int AW = $clog2(NAXES);
  localparam word_t DAC_MAX = word_t'((64'sd1 <<< (DAC_W - 1)) - 1);
  localparam word_t DAC_MIN = -DAC_MAX - word_t'(1);
  localparam logic [AW-1:0] AX_LAST = AW'(NAXES - 1);

  // ****************************************
  // Storage
  // ****************************************
  param_t prm_ff [NAXES]; // Live parameter sets
  word_t sp_ff [NAXES]; // Host setpoints
  word_t toff_ff [NAXES]; // Host torque offsets
  hist_t hist_ff [NAXES]; // Loop history
  axis_state_t st_ff [NAXES]; // Readable state
  logic [3:0] ecode_ff [NAXES]; // Sticky error bits
  word_t div_ff [NAXES]; // Ticks left to next run
  word_t ovl_ff [NAXES]; // Overload sample count
  word_t tri_ff [NAXES]; // Triangle generator value
  logic tdir_ff [NAXES]; // Triangle rising
  param_t stage_ff; // Staging set for one axis
  logic [AW-1:0] axsel_ff; // Axis the host addresses
  logic pready_ff;
  logic pslverr_ff;
  word_t prdata_ff;
  logic shut_ff; // Motors held off
  logic seen_ff; // External fault seen
  logic [2:0] hold_ff; // Ignore own fault drive echo
  logic [15:0] tcnt_ff; // Sample ticks seen
  logic tick_d_ff;
  seq_t seq_ff;
  logic [AW-1:0] ax_ff; // Axis being serviced

  // ****************************************
  // Pin inputs
  // ****************************************
  logic tick_s;
  logic panic_s;
  pin_sync u_tick (
    .sys_clk_i(sys_clk_i),
    .rst_n_i(rst_n_i),
    .pin_i(sample_tick_i),
    .level_o(tick_s)
  );
  pin_sync u_panic (
    .sys_clk_i(sys_clk_i),
    .rst_n_i(rst_n_i),
    .pin_i(~panic_n_i),
    .level_o(panic_s)
  );

  // Initial parameter set
  function automatic param_t init_param();
    param_t p;
    p = '0;
    p[`P_A0] = `RST_ONE;
    p[`P_B0] = `RST_ONE;
    p[`P_ADCA] = `RST_ONE;
    p[`P_DIV] = `RST_ONE;
    p[`P_ILIM] = DAC_MAX / word_t'(2);
    return p;
  endfunction
  // Folded to a constant so the reset branch loads constants only
  localparam param_t PRM_INIT = init_param();

  // ****************************************
  // Servo engine
  // ****************************************
  param_t prm;
  hist_t h;
  mode_t md;
  logic run_now; // Selected axis is due this tick
  logic eng_we; // Selected axis computes this cycle
  word_t phi; // Scaled A/D
  word_t y0;
  word_t spv;
  word_t vel;
  word_t err;
  word_t comp;
  word_t eng_i; // Demand after the bypass switch
  word_t eng_if; // After friction feedforward
  word_t eng_ic; // After limit clipping
  word_t eng_out; // After D/A saturation
  word_t nxt_ovl;
  word_t nxt_tri;
  logic nxt_tdir;
  logic [3:0] eng_err;

  servo_math u_math (
    .prm_i(prm),
    .hist_i(h),
    .fb_i(y0),
    .sp_i(spv),
    .vel_sel_i(md == mode_velocity),
    .open_i(prm[`P_MODE][`M_OPEN]),
    .vel_o(vel),
    .err_o(err),
    .comp_o(comp)
  );

  // Demand path; options are applied in any mix without
  always_comb begin
    prm = prm_ff[ax_ff];
    h = hist_ff[ax_ff];
    md = mode_t'(prm[`P_MODE][2:0]);
    run_now = (seq_ff == seq_run) && (div_ff[ax_ff] <= word_t'(1));
    eng_we = run_now && (md != mode_unservoed);
    phi = prm[`P_ADCA] * word_t'($signed(adc_raw_i[ax_ff]))
        + prm[`P_ADCB];
    y0 = prm[`P_MODE][`M_ANALOG_FEEDBACK_SEL] ? phi
         : word_t'(enc_count_i[ax_ff]);
    spv = prm[`P_MODE][`M_ANALOG_DEMAND_SEL] ? phi : sp_ff[ax_ff];
    // Triangle sweeps between the current limits one unit per sample
    nxt_tdir = tdir_ff[ax_ff];
    if (tri_ff[ax_ff] >= prm[`P_ILIM]) begin
      nxt_tdir = 1'b0;
    end else if (tri_ff[ax_ff] <= -prm[`P_ILIM]) begin
      nxt_tdir = 1'b1;
    end
    nxt_tri = nxt_tdir ? tri_ff[ax_ff] + word_t'(1)
                       : tri_ff[ax_ff] - word_t'(1);
    case (md)
      mode_current: begin
        eng_i = spv + (prm[`P_MODE][`M_ANALOG_TORQUE_OFFSET_SEL] ? phi
            : toff_ff[ax_ff]);
      end
      mode_triangle_test: begin
        eng_i = tri_ff[ax_ff];
      end
      default: begin
        eng_i = comp;
      end
    endcase
    eng_if = eng_i;
    if (prm[`P_MODE][`M_FRIC]) begin
      if (vel > 0 || (vel == 0 && comp > 0)) begin
        eng_if = eng_i + prm[`P_ICP];
      end else if (vel < 0 || (vel == 0 && comp < 0)) begin
        eng_if = eng_i - prm[`P_ICN];
      end
    end
    // Overload: count samples beyond the limit, or clip when P_ILIMMAX is 0
    eng_ic = eng_if;
    nxt_ovl = '0;
    eng_err = '0;
    if (eng_if > prm[`P_ILIM] || eng_if < -prm[`P_ILIM]) begin
      if (prm[`P_ILIMMAX] == '0) begin
        eng_ic = (eng_if > 0) ? prm[`P_ILIM] : -prm[`P_ILIM];
      end else begin
        nxt_ovl = ovl_ff[ax_ff] + word_t'(1);
        eng_err[`E_ILIM] = nxt_ovl > prm[`P_ILIMMAX];
      end
    end
    eng_out = eng_ic;
    if (eng_ic > DAC_MAX) begin
      eng_out = DAC_MAX;
    end else if (eng_ic < DAC_MIN) begin
      eng_out = DAC_MIN;
    end
    // Edge of the limit only, so a parked axis raises one error
    if (prm[`P_MODE][`M_PCHK]) begin
      eng_err[`E_PLO] = y0 < prm[`P_PLO] && h.y1 >= prm[`P_PLO];
      eng_err[`E_PHI] = y0 > prm[`P_PHI] && h.y1 <= prm[`P_PHI];
    end
  end

  // ****************************************
  // APB slave decode
  // ****************************************
  logic acc; // Access phase, answer not yet given
  logic wr; // Write takes effect this edge
  logic cmd_wr;
  logic cmd_rd;
  logic clr;
  word_t rd;
  logic rd_err;
  logic [4:0] pidx;
  logic ext_panic;
  logic nxt_shut;

  always_comb begin
    acc = psel_i && penable_i && !pready_ff;
    pidx = 5'((paddr_i - `A_PBASE) >> 2);
    rd = '0;
    rd_err = 1'b0;
    case (paddr_i)
      `A_AXSEL: rd = word_t'(axsel_ff);
      `A_CMD, `A_CTRL: rd = '0;
      `A_STATUS: rd = {tcnt_ff, 14'h0000, seen_ff, shut_ff};
      `A_SETPT: rd = sp_ff[axsel_ff];
      `A_TOFF: rd = toff_ff[axsel_ff];
      `A_FB: rd = st_ff[axsel_ff].fb;
      `A_VEL: rd = st_ff[axsel_ff].vel;
      `A_INOW: rd = st_ff[axsel_ff].inow;
      `A_ERR: rd = st_ff[axsel_ff].err;
      `A_ECODE: rd = word_t'(ecode_ff[axsel_ff]);
      default: begin
        if (paddr_i >= `A_PBASE && paddr_i < `A_PEND
            && paddr_i[1:0] == 2'h0) begin
          rd = stage_ff[pidx];
        end else begin
          rd_err = 1'b1; // Unmapped address
        end
      end
    endcase
    wr = psel_i && penable_i && pready_ff && pwrite_i && !pslverr_ff;
    cmd_wr = wr && paddr_i == `A_CMD && pwdata_i[`CMD_WR];
    cmd_rd = wr && paddr_i == `A_CMD && pwdata_i[`CMD_RD];
    clr = wr && paddr_i == `A_CTRL && pwdata_i[`CTRL_CLR];
    // Our own drive echoes back through the synchroniser; ignore it
    ext_panic = panic_s && !panic_oe_o && hold_ff == 3'h0;
    // Set wins over clear
    nxt_shut = (shut_ff && !clr) || ext_panic
             || (wr && paddr_i == `A_CTRL && pwdata_i[`CTRL_OFF])
             || (eng_we && |eng_err
                 && !prm[`P_MODE][`M_SOFT]);
  end

  // ****************************************
  // Bus, control and sequencer registers
  // ****************************************
  always_ff @(posedge sys_clk_i or negedge rst_n_i) begin
    if (!rst_n_i) begin
      pready_ff <= 1'b0;
      pslverr_ff <= 1'b0;
      prdata_ff <= '0;
      axsel_ff <= '0;
      stage_ff <= '0;
      shut_ff <= 1'b0;
      seen_ff <= 1'b0;
      hold_ff <= 3'h0;
      tcnt_ff <= 16'h0000;
      tick_d_ff <= 1'b0;
      seq_ff <= seq_idle;
      ax_ff <= '0;
    end else begin
      pready_ff <= acc;
      pslverr_ff <= acc && rd_err;
      prdata_ff <= acc ? rd : '0;
      if (wr && paddr_i == `A_AXSEL) begin
        axsel_ff <= pwdata_i[AW-1:0];
      end
      if (cmd_rd) begin
        stage_ff <= prm_ff[axsel_ff];
      end else if (wr && paddr_i >= `A_PBASE && paddr_i < `A_PEND) begin
        stage_ff[pidx] <= pwdata_i;
      end
      shut_ff <= nxt_shut;
      seen_ff <= (seen_ff && !clr) || ext_panic;
      hold_ff <= panic_oe_o ? `PANIC_HOLD
               : (hold_ff == 3'h0 ? 3'h0 : hold_ff - 3'h1);
      tick_d_ff <= tick_s;
      // All axes start from the one common tick
      if (seq_ff == seq_idle && tick_s && !tick_d_ff) begin
        seq_ff <= seq_run;
        ax_ff <= '0;
        tcnt_ff <= tcnt_ff + 16'h0001;
      end else if (seq_ff == seq_run) begin
        ax_ff <= ax_ff + AW'(1);
        if (ax_ff == AX_LAST) begin
          seq_ff <= seq_idle;
        end
      end
    end
  end

  // ****************************************
  // Per axis arrays
  // ****************************************
  always_ff @(posedge sys_clk_i or negedge rst_n_i) begin
    if (!rst_n_i) begin
      for (int a = 0; a < NAXES; a++) begin
        prm_ff[a] <= PRM_INIT;
        sp_ff[a] <= '0;
        toff_ff[a] <= '0;
        hist_ff[a] <= '0;
        st_ff[a] <= '0;
        ecode_ff[a] <= 4'h0;
        div_ff[a] <= `RST_ONE;
        ovl_ff[a] <= '0;
        tri_ff[a] <= '0;
        tdir_ff[a] <= 1'b1;
        dac_o[a] <= '0;
      end
      panic_n_o <= 1'b0;
      panic_oe_o <= 1'b0;
    end else begin
      panic_n_o <= 1'b0;
      panic_oe_o <= nxt_shut;
      for (int a = 0; a < NAXES; a++) begin
        if (clr) begin
          ecode_ff[a] <= 4'h0;
        end
        if (ext_panic) begin
          ecode_ff[a] <= (clr ? 4'h0 : ecode_ff[a]) | 4'h8;
        end
        if (nxt_shut) begin
          dac_o[a] <= '0;
        end
      end
      if (seq_ff == seq_run) begin
        div_ff[ax_ff] <= run_now ? prm[`P_DIV] : div_ff[ax_ff] - 1;
      end
      if (run_now && md == mode_unservoed && !nxt_shut) begin
        dac_o[ax_ff] <= '0;
      end
      if (eng_we) begin
        hist_ff[ax_ff] <= '{err, h.e1, comp, h.u1, y0, h.y1};
        st_ff[ax_ff] <= '{y0, vel, eng_out, err};
        ovl_ff[ax_ff] <= nxt_ovl;
        tri_ff[ax_ff] <= nxt_tri;
        tdir_ff[ax_ff] <= nxt_tdir;
        // A panic in the same cycle must still set its bit
        ecode_ff[ax_ff] <= (clr ? 4'h0 : ecode_ff[ax_ff]) | eng_err
                           | {ext_panic, 3'h0};
        if (!nxt_shut) begin
          dac_o[ax_ff] <= DAC_W'(eng_out);
        end
      end
      // Rewrite after the engine so a fresh set starts from rest
      if (cmd_wr) begin
        prm_ff[axsel_ff] <= stage_ff;
        hist_ff[axsel_ff] <= '0;
        div_ff[axsel_ff] <= `RST_ONE;
        ovl_ff[axsel_ff] <= '0;
        tri_ff[axsel_ff] <= '0;
      end
      if (wr && paddr_i == `A_SETPT) begin
        sp_ff[axsel_ff] <= pwdata_i;
      end
      if (wr && paddr_i == `A_TOFF) begin
        toff_ff[axsel_ff] <= pwdata_i;
      end
    end
  end

  assign prdata_o = prdata_ff;
  assign pready_o = pready_ff;
  assign pslverr_o = pslverr_ff;

  // ****************************************
  // Assertions
  // ****************************************
  default clocking cb @(posedge sys_clk_i); endclocking
  default disable iff (!rst_n_i);

  off_zero_a: assert property (
    run_now && md == mode_unservoed |=> dac_o[$past(ax_ff)] == '0)
    else $error("unservoed axis drives current");
  shut_zero_a: assert property (
    shut_ff ##1 shut_ff |-> dac_o == '0 && panic_oe_o)
    else $error("shutdown leaves current or fault line");
  torque_bypass_a: assert property (
    eng_we && md == mode_current && !prm[`P_MODE][`M_ANALOG_DEMAND_SEL]
    && !prm[`P_MODE][`M_ANALOG_TORQUE_OFFSET_SEL] |-> eng_i == sp_ff[ax_ff] + toff_ff[ax_ff])
    else $error("current mode not bypassing compensator");
  loop_error_a: assert property (
    eng_we && md == mode_position && !prm[`P_MODE][`M_ANALOG_DEMAND_SEL]
    && !prm[`P_MODE][`M_OPEN] |=> st_ff[$past(ax_ff)].err
    == $past(sp_ff[ax_ff]) - $past(y0))
    else $error("error is not setpoint minus feedback");
  friction_dir_a: assert property (
    eng_we && prm[`P_MODE][`M_FRIC] && vel == 0 && comp > 0
    |-> eng_if == eng_i + prm[`P_ICP])
    else $error("friction direction ignores demand sign");
  limit_edge_a: assert property (
    eng_we && eng_err[`E_PLO] |-> h.y1 >= prm[`P_PLO] && y0 < prm[`P_PLO])
    else $error("low limit flagged without crossing");
  clip_a: assert property (
    eng_we && prm[`P_ILIMMAX] == '0 && prm[`P_ILIM] >= 0
    |-> eng_ic <= prm[`P_ILIM] && eng_ic >= -prm[`P_ILIM] && !eng_err[2])
    else $error("current not clipped to limit");
  divisor_a: assert property (
    run_now && !cmd_wr |=> div_ff[$past(ax_ff)] == $past(prm[`P_DIV]))
    else $error("divisor not reloaded after run");
  sweep_a: assert property (
    seq_ff == seq_idle ##1 seq_ff == seq_run |-> ax_ff == '0)
    else $error("sweep does not start at axis zero");

  tick_c: cover property (seq_ff == seq_idle ##1 seq_ff == seq_run);
  vel_c: cover property (eng_we && md == mode_velocity);
  shut_c: cover property ($rose(shut_ff));
endmodule // servo_ctrl

// ---- verification/card_model.sv ----
`timescale 1ns/1ps
// ********
// Motor card rack: tick, encoders, A/D, fault line
// ********
module card_model #(
  parameter int NAXES = 16,
  parameter int ADC_W = 16
) (
  // Clock and controller fault drive
  input wire logic sys_clk_i,
  input wire logic panic_oe_i,
  // Card side outputs
  output logic sample_tick_o,
  output logic panic_n_o,
  output logic [NAXES-1:0][31:0] enc_count_o,
  output logic [NAXES-1:0][ADC_W-1:0] adc_raw_o
);
  logic fault_ff; // A card reporting a failure
  initial begin
    sample_tick_o = 1'b0;
    fault_ff = 1'b0;
    enc_count_o = '0;
    adc_raw_o = '0;
  end
  // Pulled-up line, so it reads high, no fault, unless a side pulls it low
  assign panic_n_o = (panic_oe_i || fault_ff) ? 1'b0 : 1'b1;
  // One tick shared by all cards, held for a chosen time
  task automatic tick(input int hold);
    @(posedge sys_clk_i);
    sample_tick_o <= 1'b1;
    repeat (hold) @(posedge sys_clk_i);
    sample_tick_o <= 1'b0;
  endtask
  // New sensor readings of one card
  task automatic set_axis(input int k, input logic [31:0] e,
                          input logic [ADC_W-1:0] a);
    @(posedge sys_clk_i);
    enc_count_o[k] <= e;
    adc_raw_o[k] <= a;
  endtask
  // A card pulls or frees the fault line
  task automatic set_fault(input logic f);
    @(posedge sys_clk_i);
    fault_ff <= f;
  endtask
endmodule // card_model

// ---- verification/axis_servo_controller_tb.sv ----
`timescale 1ns/1ps
`include "servo_map.svh"
// ********
// Servo controller bench
// ********
module axis_servo_controller_tb;
  localparam int NAXES = 16;
  localparam int ADC_W = 16;
  logic sys_clk; // Bench clock
  logic rst_n; // Reset, low active
  logic psel, penable, pwrite, pready, pslverr;
  logic [7:0] paddr;
  logic [31:0] pwdata, prdata, rq;
  logic re, tick, fault_n, drive_oe, pn;
  logic [NAXES-1:0][31:0] enc;
  logic [NAXES-1:0][ADC_W-1:0] adc;
  logic [NAXES-1:0][15:0] dac;
  int fail_count, samples_checked, h1, h2, fb, v, spv, dm;
  int seed = 32'hCDAC188A; // Fixed so runs repeat
  servo_ctrl u_servo_ctrl (
    .sys_clk_i(sys_clk), .rst_n_i(rst_n), .psel_i(psel),
    .penable_i(penable), .pwrite_i(pwrite), .paddr_i(paddr),
    .pwdata_i(pwdata), .prdata_o(prdata), .pready_o(pready),
    .pslverr_o(pslverr), .sample_tick_i(tick), .panic_n_i(fault_n),
    .panic_n_o(pn), .panic_oe_o(drive_oe), .enc_count_i(enc),
    .adc_raw_i(adc), .dac_o(dac)
  );
  card_model u_card_model (
    .sys_clk_i(sys_clk), .panic_oe_i(drive_oe), .sample_tick_o(tick),
    .panic_n_o(fault_n), .enc_count_o(enc), .adc_raw_o(adc)
  );
  initial begin
    sys_clk = 1'b0;
    forever #4 sys_clk = ~sys_clk;
  end
  // Compare and count
  task automatic chk(input logic [31:0] got, input logic [31:0] exp);
    samples_checked++;
    if (got !== exp) begin
      fail_count++;
      $display("Error at %0t: got %h, expected %h", $time, got, exp);
    end
  endtask
  // One bus transfer; waits for the slave however long it takes
  task automatic apb(input logic w, input logic [7:0] a,
                     input logic [31:0] d, output logic [31:0] q,
                     output logic e);
    @(posedge sys_clk);
    psel <= 1'b1;
    pwrite <= w;
    paddr <= a;
    pwdata <= d;
    @(posedge sys_clk);
    penable <= 1'b1;
    // Only the watchdog ends a wait that never gets an answer
    do begin
      @(posedge sys_clk);
    end while (pready !== 1'b1);
    q = prdata;
    e = pslverr;
    psel <= 1'b0;
    penable <= 1'b0;
  endtask
  task automatic wr(input logic [7:0] a, input logic [31:0] d);
    logic [31:0] q;
    logic e;
    apb(1'b1, a, d, q, e);
  endtask
  // Staging parameter write
  task automatic wp(input int k, input int d);
    wr(8'(`A_PBASE + 4 * k), 32'(d));
  endtask
  function automatic int rnd(input int lo, input int hi);
    return lo + int'($unsigned($random(seed)) % (hi - lo + 1));
  endfunction
  function automatic logic [31:0] init_val(input int k);
    case (k)
      `P_A0, `P_B0, `P_DIV, `P_ADCA: return 32'h00000001;
      `P_ILIM: return 32'h00003FFF;
      default: return 32'h00000000;
    endcase
  endfunction
  // Demand from mode, setpoint, feedback and velocity
  function automatic int demand(input int md, input int fr, input int sp,
                                input int f, input int vl, input int a0,
                                input int b0, input int toff);
    int u;
    if (md == 0) return 0;
    if (md == 3) return sp + toff;
    u = a0 * (sp - (md == 2 ? vl : f)) / b0;
    if (fr == 0) return u;
    if (vl > 0 || (vl == 0 && u > 0)) return u + 100;
    if (vl < 0 || u < 0) return u - 50;
    return u;
  endfunction
  task automatic give_verdict();
    $display("Compared %0d, failed %0d", samples_checked, fail_count);
    if (fail_count == 0 && samples_checked > 0) begin
      $display("All checks passed");
    end else begin
      $display("Checks failed");
    end
    $finish;
  endtask
  // Main sequence
  initial begin
    int ax, md, fr, afb, adm, a0, b0, sp, toff, ev, av;
    int opn, aof, lim, tn, fs;
    psel = 1'b0;
    penable = 1'b0;
    pwrite = 1'b0;
    paddr = 8'h00;
    pwdata = 32'h00000000;
    rst_n = 1'b0;
    repeat (16) @(posedge sys_clk);
    rst_n <= 1'b1;
    chk({31'h0, |dac}, 32'h0);
    // Probe every axis and check its start-up parameters
    for (int i = 0; i < NAXES; i++) begin
      wr(`A_AXSEL, 32'(i));
      wr(`A_CMD, 32'h1 << `CMD_RD);
      for (int k = 0; k < `PARAM_N; k++) begin
        apb(1'b0, 8'(`A_PBASE + 4 * k), '0, rq, re);
        chk(rq, init_val(k));
      end
    end
    // Refused access
    apb(1'b0, 8'hF0, '0, rq, re);
    chk(rq, 32'h0);
    chk({31'h0, re}, 32'h1);
    // Random modes and options, three samples each
    // Every mode once first, then random ones
    for (int it = 0; it < 15; it++) begin
      ax = rnd(0, NAXES - 1);
      md = (it < 5) ? it : rnd(0, 4);
      fr = (md < 3) ? rnd(0, 1) : 0;
      opn = (md == 1) ? rnd(0, 1) : 0;
      aof = (md == 3) ? rnd(0, 1) : 0;
      lim = rnd(200, 9000);
      afb = rnd(0, 1);
      adm = rnd(0, 1);
      a0 = rnd(1, 2);
      b0 = rnd(1, 2);
      sp = rnd(-1000, 1000);
      toff = rnd(0, 500);
      wr(`A_AXSEL, 32'(ax));
      wp(`P_A0, a0);
      wp(`P_B0, b0);
      wp(`P_ADCA, 2);
      wp(`P_ADCB, -7);
      wp(`P_ICP, 100);
      wp(`P_ICN, 50);
      wp(`P_ILIM, lim);
      wp(`P_MODE, md | (fr << 4) | (afb << 5) | (opn << 6)
         | (adm << 7) | (aof << 8));
      wr(`A_CMD, 32'h1 << `CMD_WR);
      wr(`A_SETPT, 32'(sp));
      wr(`A_TOFF, 32'(toff));
      h1 = 0;
      h2 = 0;
      tn = 0;
      repeat (3) begin
        ev = rnd(-1000, 1000);
        av = rnd(-500, 500);
        u_card_model.set_axis(ax, 32'(ev), ADC_W'(av));
        // Two cycles at least: the pin filter drops a one-cycle pulse
        u_card_model.tick(rnd(2, 4));
        repeat (NAXES + 8) @(posedge sys_clk);
        fb = afb ? 2 * av - 7 : ev;
        spv = adm ? 2 * av - 7 : sp;
        v = (3 * fb - 4 * h1 + h2) / 2;
        fs = (md == 2) ? v : (opn ? 0 : fb);
        dm = demand(md, fr, spv, opn ? 0 : fb, v, a0, b0,
                    aof ? 2 * av - 7 : toff);
        if (md == 4) dm = tn;
        if (md != 0 && dm > lim) dm = lim;
        if (md != 0 && dm < -lim) dm = -lim;
        chk({16'h0, dac[ax]}, {16'h0, 16'(dm)});
        if (md == 1 || md == 2) begin
          apb(1'b0, `A_FB, '0, rq, re);
          chk(rq, 32'(fb));
          apb(1'b0, `A_VEL, '0, rq, re);
          chk(rq, 32'(v));
          apb(1'b0, `A_ERR, '0, rq, re);
          chk(rq, 32'(spv - fs));
        end
        h2 = h1;
        h1 = fb;
        tn++;
      end
    end
    // Forced shutdown, then a card fault
    wr(`A_CTRL, 32'h1 << `CTRL_OFF);
    repeat (4) @(posedge sys_clk);
    chk({31'h0, |dac}, 32'h0);
    chk({31'h0, fault_n}, 32'h0);
    chk({31'h0, pn}, 32'h0);
    wr(`A_CTRL, 32'h1 << `CTRL_CLR);
    repeat (12) @(posedge sys_clk);
    chk({31'h0, fault_n}, 32'h1);
    u_card_model.set_fault(1'b1);
    repeat (8) @(posedge sys_clk);
    apb(1'b0, `A_STATUS, '0, rq, re);
    chk(rq & 32'h3, 32'h3);
    u_card_model.set_fault(1'b0);
    wr(`A_CTRL, 32'h1 << `CTRL_CLR);
    repeat (12) @(posedge sys_clk);
    apb(1'b0, `A_STATUS, '0, rq, re);
    chk(rq & 32'h3, 32'h0);
    give_verdict();
  end
  // Hang guard, well past the expected run length
  initial begin
    repeat (20000) @(posedge sys_clk);
    fail_count++;
    $display("Error at %0t: run did not finish", $time);
    give_verdict();
  end
endmodule // axis_servo_controller_tb
